/* File: sswd_defines.svh */
`ifndef SSWD_DEFINES_SVH
`define SSWD_DEFINES_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SSWD_CLK_HZ          25000000
`define SSWD_RST_SHORT_MS    50
`define SSWD_RST_LONG_MS     200
`define SSWD_WD_LONG_MS      1600
`define SSWD_WD_SHORT_MS     100
`define SSWD_MS_TO_CYC(ms)   ((ms) * (`SSWD_CLK_HZ / 1000))
`define SSWD_CNT_W           26

`endif

/* File: sswd_pkg.sv */
package sswd_pkg;

  // ----------------------------------------
  // Watchdog states
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    SSWD_OFF   = 3'b001,
    SSWD_COUNT = 3'b010,
    SSWD_PULSE = 3'b100
  } sswd_state_t;

endpackage

/* File: sswd_sync.sv */
module sswd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------
  // Two flip-flop synchroniser
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    // Preload the pin level so no false level shows after reset release
    if (!rst_n)
    begin
      stage1 <= din;
      dout   <= din;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

/* File: sswd_top.sv */
`include "sswd_defines.svh"

// Summary of operation
// R1 - Hold reset low while supply is below the reset threshold.
// R2 - Keep reset low 50 ms, or 200 ms long option, after recovery.
// R3 - Warning output low while sense input is below reference.
// R4 - Gated chip select follows chip select input when supply is good.
// R5 - Gated chip select forced high when supply is below threshold.
// R6 - Processor must toggle the kick input at least every 1.6 s.
// R7 - Missed kick period produces a 50 or 200 ms reset pulse.
// R8 - Reset pulses repeat every period until a kick is seen.
// R9 - Expiry output goes low when a period passes without kick.
// R10 - Expiry output stays low until the next kick transition.
// R11 - Floating kick input disables the watchdog entirely.
// R12 - Source select low uses external period ticks for the watchdog.
// R13 - Source select high uses internal 100 ms or 1.6 s period.
// R14 - Battery switch low while supply exceeds battery, high on battery.
// R15 - Gated chip select held high during battery backup.
// R16 - Active-high reset is always the inverse of active-low reset.
// R17 - After any reset the long period applies until first kick; the code skips this after a watchdog reset pulse.
// R18 - Period input low selects 100 ms, high selects 1.6 s.
// R19 - Expiry output forced high when supply is below threshold.
// R20 - Kick input ignored during battery backup.
// R21 - Comparator flags are synchronised before use.
// R22 - Any change of synchronised kick level restarts the period.
module sswd_top #(
  parameter int RST_SHORT_CYC = `SSWD_MS_TO_CYC(`SSWD_RST_SHORT_MS),
  parameter int RST_LONG_CYC  = `SSWD_MS_TO_CYC(`SSWD_RST_LONG_MS),
  parameter int WD_LONG_CYC   = `SSWD_MS_TO_CYC(`SSWD_WD_LONG_MS),
  parameter int WD_SHORT_CYC  = `SSWD_MS_TO_CYC(`SSWD_WD_SHORT_MS),
  parameter int EXT_TICKS     = 16
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Comparator flags
  input  wire logic supply_low,
  input  wire logic supply_below_batt,
  input  wire logic supply_warn_sense,
  // Options
  input  wire logic long_pulse_opt,
  // Watchdog
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_kick_float,
  input  wire logic timebase_source_sel,
  input  wire logic timebase_period_in,
  // Chip select
  input  wire logic chip_sel_in_n,
  output logic      chip_sel_out_n,
  // Status
  output logic      proc_reset_n,
  output logic      proc_reset,
  output logic      supply_warn_n,
  output logic      watchdog_expired_n,
  output logic      battery_switch_drive
);

  localparam int CW = `SSWD_CNT_W;
  localparam logic [CW-1:0] CW_ONE = CW'(1);

  logic [4:0]             sync_q;
  logic                   s_low;
  logic                   s_batt;
  logic                   s_warn;
  logic                   s_kick;
  logic                   s_float;
  logic                   kick_prev;
  logic                   kick_edge;
  logic                   ext_prev;
  logic                   ext_tick;
  logic                   first_kick_seen;
  logic [CW-1:0]          hold_cnt;
  logic [CW-1:0]          wd_cnt;
  logic [CW-1:0]          pulse_cnt;
  logic [CW-1:0]          wd_limit;
  logic [CW-1:0]          pulse_len;
  logic                   wd_step;
  logic                   wd_active;
  sswd_pkg::sswd_state_t  state;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  // R21 synchronise flags
  sswd_sync #(
    .WIDTH (5)
  ) sswd_sync_inst (
    .clock (clock),
    .rst_n (rst_n),
    .din   ({supply_low, supply_below_batt, supply_warn_sense,
             watchdog_kick_in, watchdog_kick_float}),
    .dout  (sync_q)
  );

  assign s_low   = sync_q[4];
  assign s_batt  = sync_q[3];
  assign s_warn  = sync_q[2];
  assign s_kick  = sync_q[1];
  assign s_float = sync_q[0];

  // ----------------------------------------
  // Period selection
  // ----------------------------------------
  function automatic logic [CW-1:0] to_cw(input int v);
    to_cw = CW'(v);
  endfunction

  assign pulse_len = long_pulse_opt ? to_cw(RST_LONG_CYC) : to_cw(RST_SHORT_CYC);

  // R12 external timebase
  // R13 internal periods
  // R17 long after reset
  // R18 period select
  always_comb
  begin
    if (!timebase_source_sel)
      wd_limit = to_cw(EXT_TICKS);
    else if (!timebase_period_in && first_kick_seen)
      wd_limit = to_cw(WD_SHORT_CYC);
    else
      wd_limit = to_cw(WD_LONG_CYC);
  end

  // External period input counts rising edges as ticks
  assign ext_tick = timebase_period_in & ~ext_prev;
  assign wd_step  = timebase_source_sel | ext_tick;

  // R11 float disables
  // R20 ignore in backup
  assign wd_active = ~s_float & ~s_batt & ~s_low;
  // R22 kick edge detect
  assign kick_edge = (s_kick != kick_prev) & wd_active;

  always_ff @(posedge clock)
  begin
    // Start from the present levels so reset never makes a false edge
    if (!rst_n)
    begin
      kick_prev <= s_kick;
      ext_prev  <= timebase_period_in;
    end
    else
    begin
      kick_prev <= s_kick;
      ext_prev  <= timebase_period_in;
    end
  end

  // ----------------------------------------
  // Power-on reset stretch
  // ----------------------------------------
  // R2 stretch after recovery
  always_ff @(posedge clock)
  begin
    // Reset release counts as power-up, so the stretch applies then too
    if (!rst_n)
      hold_cnt <= pulse_len;
    else if (s_low)
      hold_cnt <= pulse_len;
    else if (hold_cnt != '0)
      hold_cnt <= hold_cnt - CW_ONE;
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n || s_low || hold_cnt != '0)
      first_kick_seen <= 1'b0;
    else if (kick_edge)
      first_kick_seen <= 1'b1;
  end

  // R7 timeout pulse
  // R8 repeat pulses
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state     <= sswd_pkg::SSWD_OFF;
      wd_cnt    <= '0;
      pulse_cnt <= '0;
    end
    else if (!wd_active || hold_cnt != '0 || kick_edge)
    begin
      // Kicks and power resets both restart the period
      state     <= wd_active ? sswd_pkg::SSWD_COUNT : sswd_pkg::SSWD_OFF;
      wd_cnt    <= '0;
      pulse_cnt <= '0;
    end
    else
    begin
      case (state)
        sswd_pkg::SSWD_OFF:
          state <= sswd_pkg::SSWD_COUNT;
        sswd_pkg::SSWD_COUNT:
        begin
          if (wd_step)
          begin
            if (wd_cnt + CW_ONE >= wd_limit)
            begin
              wd_cnt    <= '0;
              pulse_cnt <= pulse_len;
              state     <= sswd_pkg::SSWD_PULSE;
            end
            else
              wd_cnt <= wd_cnt + CW_ONE;
          end
        end
        sswd_pkg::SSWD_PULSE:
        begin
          // Period keeps running during the pulse so pulses repeat each period
          if (wd_step)
            wd_cnt <= wd_cnt + CW_ONE;
          if (pulse_cnt <= CW_ONE)
            state <= sswd_pkg::SSWD_COUNT;
          pulse_cnt <= pulse_cnt - CW_ONE;
        end
        default:
          state <= sswd_pkg::SSWD_OFF;
      endcase
    end
  end

  // R9 expiry low
  // R10 held until kick
  // R19 high on low supply
  always_ff @(posedge clock)
  begin
    if (!rst_n || s_low || s_batt || kick_edge || s_float)
      watchdog_expired_n <= 1'b1;
    else if (state == sswd_pkg::SSWD_COUNT && wd_step && wd_cnt + CW_ONE >= wd_limit)
      watchdog_expired_n <= 1'b0;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      proc_reset_n         <= 1'b0;
      proc_reset           <= 1'b1;
      supply_warn_n        <= 1'b1;
      chip_sel_out_n       <= 1'b1;
      battery_switch_drive <= 1'b0;
    end
    else
    begin
      // R1 reset on low supply
      // R16 complementary reset
      proc_reset_n   <= !(s_low || hold_cnt != '0 || state == sswd_pkg::SSWD_PULSE);
      proc_reset     <= (s_low || hold_cnt != '0 || state == sswd_pkg::SSWD_PULSE);
      // R3 warning follows comparator, low when backed up
      supply_warn_n  <= s_warn && !s_batt;
      // R4 chip select follows
      // R5 forced high low supply
      // R15 forced high in backup
      chip_sel_out_n <= chip_sel_in_n || s_low || s_batt;
      // R14 battery switch
      battery_switch_drive <= s_batt;
    end
  end

endmodule

/* File: sswd_properties.sv */
module sswd_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Inputs
  input wire logic supply_low,
  input wire logic supply_below_batt,
  input wire logic supply_warn_sense,
  input wire logic chip_sel_in_n,
  // Outputs
  input wire logic chip_sel_out_n,
  input wire logic proc_reset_n,
  input wire logic proc_reset,
  input wire logic supply_warn_n,
  input wire logic watchdog_expired_n,
  input wire logic battery_switch_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Five cycles cover the two-flop synchroniser plus the output register
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_reset_inverse: assert property (proc_reset == !proc_reset_n)
    else $error("reset outputs not complementary");
  a_reset_low: assert property (supply_low [*5] |-> !proc_reset_n)
    else $error("reset released while supply low");
  a_cs_gate: assert property (supply_low [*5] |-> chip_sel_out_n)
    else $error("chip select passed while supply low");
  a_cs_follow: assert property ((!supply_low && !supply_below_batt) [*6]
    |-> chip_sel_out_n == $past(chip_sel_in_n)) else $error("chip select not following");
  a_backup_gate: assert property (supply_below_batt [*5]
    |-> chip_sel_out_n && battery_switch_drive) else $error("backup outputs wrong");
  a_batt_off: assert property (!supply_below_batt [*5] |-> !battery_switch_drive)
    else $error("battery switch high on main supply");
  a_warn_low: assert property (!supply_warn_sense [*5] |-> !supply_warn_n)
    else $error("warning not raised");
  a_expiry_high: assert property (supply_low [*5] |-> watchdog_expired_n)
    else $error("expiry low while supply low");
  a_expiry_pulse: assert property ($fell(watchdog_expired_n) |=> !proc_reset_n [*8])
    else $error("no reset pulse after expiry");
endmodule

/* File: sswd_proc_model.sv */
module sswd_proc_model (
  // Control
  input  wire logic clock,
  input  wire logic run,
  // Kick line
  output logic      kick
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic run_q = 1'b0;
  initial kick = 1'b0;
  // Run is taken on the rising edge so the bench's falling-edge writes never race
  always @(posedge clock)
    run_q <= run;
  always @(negedge clock)
  begin
    cnt = run_q ? cnt + 1 : 0;
    if (cnt == 30)
    begin
      kick <= ~kick;
      cnt = 0;
    end
  end
endmodule

/* File: sswd_top_test.sv */
module sswd_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sl = 1'b1;
  logic sb = 1'b0;
  logic ws = 1'b1;
  logic lp = 1'b0;
  logic fl = 1'b0;
  logic ts = 1'b1;
  logic tp = 1'b1;
  logic cs = 1'b1;
  logic run = 1'b0;
  logic kick, cso, rn, rh, wn, en, bd;
  int   n_errors = 0;
  int   total_checks = 0;
  int   cyc = 0;
  int   n;
  always #20 clock = ~clock;
  sswd_proc_model sswd_proc_model_inst (.clock(clock), .run(run), .kick(kick));
  // Short counts keep the run brief; expectations below assume these
  sswd_top #(.RST_SHORT_CYC(20), .RST_LONG_CYC(40), .WD_LONG_CYC(200),
    .WD_SHORT_CYC(50)) sswd_top_inst (.clock(clock), .rst_n(rst_n),
    .supply_low(sl), .supply_below_batt(sb), .supply_warn_sense(ws),
    .long_pulse_opt(lp), .watchdog_kick_in(kick), .watchdog_kick_float(fl),
    .timebase_source_sel(ts), .timebase_period_in(tp), .chip_sel_in_n(cs),
    .chip_sel_out_n(cso), .proc_reset_n(rn), .proc_reset(rh),
    .supply_warn_n(wn), .watchdog_expired_n(en), .battery_switch_drive(bd));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, lo);
    end
  endtask
  // Cycles until reset (s=0) or expiry (s=1) output reaches v
  task automatic wait_lvl(input bit s, input logic v);
    n = 0;
    while ((s ? en : rn) !== v && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic test_done;
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      test_done;
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    tick(12);
    rst_n = 1'b1;
    tick(10);
    chk(rn, 1'b0);
    chk(cso, 1'b1);
    chk(en, 1'b1);
    chk(rh, 1'b1);
    sl = 1'b0;
    wait_lvl(0, 1'b1);
    chk_rng(n, 20, 25);
    run = 1'b1;
    cs = 1'b0;
    tick(2);
    chk(cso, 1'b0);
    ws = 1'b0;
    tick(5);
    chk(wn, 1'b0);
    ws = 1'b1;
    sb = 1'b1;
    tick(6);
    chk(bd, 1'b1);
    chk(cso, 1'b1);
    sb = 1'b0;
    tick(600);
    chk(en, 1'b1);
    chk(rn, 1'b1);
    // Missed kicks: expiry, pulse, repeat, then a kick clears expiry
    run = 1'b0;
    wait_lvl(1, 1'b0);
    chk_rng(n, 165, 210);
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    chk_rng(n, 20, 21);
    wait_lvl(0, 1'b0);
    chk_rng(n, 176, 184);
    chk(en, 1'b0);
    run = 1'b1;
    tick(70);
    chk(en, 1'b1);
    lp = 1'b1;
    run = 1'b0;
    wait_lvl(1, 1'b0);
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    chk_rng(n, 40, 41);
    lp = 1'b0;
    run = 1'b1;
    tick(70);
    fl = 1'b1;
    run = 1'b0;
    tick(400);
    chk(en, 1'b1);
    chk(rn, 1'b1);
    fl = 1'b0;
    // Short period only after the first kick following a reset
    tp = 1'b0;
    sl = 1'b1;
    tick(8);
    sl = 1'b0;
    wait_lvl(0, 1'b1);
    tick(120);
    chk(en, 1'b1);
    run = 1'b1;
    tick(31);
    run = 1'b0;
    wait_lvl(1, 1'b0);
    chk_rng(n, 40, 56);
    // External timebase: sixteen rising edges on the period input time out
    ts = 1'b0;
    run = 1'b1;
    tick(40);
    run = 1'b0;
    chk(en, 1'b1);
    repeat (15)
    begin
      tp = 1'b1;
      tick(1);
      tp = 1'b0;
      tick(1);
    end
    chk(en, 1'b1);
    tp = 1'b1;
    tick(2);
    chk(en, 1'b0);
    chk(rn, 1'b0);
    test_done;
  end
endmodule
bind sswd_top sswd_properties sswd_properties_inst (.clock, .rst_n, .supply_low,
  .supply_below_batt, .supply_warn_sense, .chip_sel_in_n, .chip_sel_out_n,
  .proc_reset_n, .proc_reset, .supply_warn_n, .watchdog_expired_n, .battery_switch_drive);
